// *** pkg/pdao_defs.svh ***
// Pin positions and reset values for the port D/E override logic
`ifndef PDAO_DEFS_SVH
`define PDAO_DEFS_SVH
`define PDAO_D_EXTIRQ0 1
`define PDAO_D_CAPTURE 0
`define PDAO_E_CLKOUT 7
`define PDAO_E_USIDO 6
`define PDAO_E_USIDI 5
`define PDAO_E_USICK 4
`define PDAO_E_CMPNEG 3
`define PDAO_E_XCK 2
`define PDAO_E_TXD 1
`define PDAO_E_RXD 0
`define PDAO_RST_OEN 8'hFF
`define PDAO_RST_ZERO 8'h00
`define PDAO_RST_BIT 1'h0
`endif

// *** pkg/pdao_pkg.sv ***
// Types shared by the port D/E override logic
package pdao_pkg;
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic outval_override_enable;
    logic outval_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } pdao_ovr_s;
  typedef struct packed {
    logic pullEn;
    logic dirOut;
    logic outVal;
    logic inEn;
  } pdao_pad_s;
endpackage

// *** rtl/pdao_port_mux.sv ***
// Alternate-function override logic for ports D and E
`include "pdao_defs.svh"
module pdao_port_mux
  import pdao_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic clock, // 20 MHz system clock
  input wire logic srst, // Sync reset, active high
  input wire logic [PINS-1:0] portDDir, // Port D direction bits
  input wire logic [PINS-1:0] portDOut, // Port D output bits
  input wire logic [PINS-1:0] portDPinIn, // Port D pad levels
  input wire logic [PINS-1:0] portEDir, // Port E direction bits
  input wire logic [PINS-1:0] portEOut, // Port E output bits
  input wire logic [PINS-1:0] portEPinIn, // Port E pad levels
  input wire logic globalPullupDisable, // Disables all port pull-ups
  input wire logic sleepInputDisable, // Default input buffer off
  input wire logic extIrq0Enable, // External irq 0 enabled
  input wire logic clockOutFuse, // Clock-out fuse programmed
  input wire logic dividedClock, // Divided I/O clock level
  input wire logic univSerialTwowireMode, // Serial unit two-wire
  input wire logic univSerialThreewireMode, // Serial unit three-wire
  input wire logic univSerialDataOut, // Serial data out (3-wire)
  input wire logic univSerialSdaOut, // Serial data bit (2-wire)
  input wire logic clockStretchHold, // Two-wire clock hold
  input wire logic clockToggleStrobe, // Toggles E4 output bit in two-wire mode
  input wire logic startDetectIrqEnable, // Start-detect irq enable
  input wire logic pinchangeGroup0Enable, // Port E pinchange group
  input wire logic [PINS-1:0] pinchangeMaskE, // Port E pinchange masks
  input wire logic cmpPosDinDisable, // E2 digital input disable
  input wire logic cmpNegDinDisable, // E3 digital input disable
  input wire logic usartSyncMode, // USART synchronous mode
  input wire logic syncSerialClockOut, // USART clock to drive
  input wire logic transmitterEnableBit, // USART transmitter on
  input wire logic txData, // USART transmit stream
  input wire logic receiverEnableBit, // USART receiver on
  input wire logic jtagEnable, // Boundary-scan port enabled
  output logic [PINS-1:0] portDOutVal_q, // Port D pad drive value
  output logic [PINS-1:0] portDOeN_q, // Port D drive enable, low
  output logic [PINS-1:0] portDPullEn_q, // Port D pull-up enable
  output logic [PINS-1:0] portDInEn_q, // Port D input buffer on
  output logic [PINS-1:0] portEOutVal_q, // Port E pad drive value
  output logic [PINS-1:0] portEOeN_q, // Port E drive enable, low
  output logic [PINS-1:0] portEPullEn_q, // Port E pull-up enable
  output logic [PINS-1:0] portEInEn_q, // Port E input buffer on
  output logic extIrq0Input_q, // Level to irq 0 logic
  output logic timer16CaptureInput_q, // Level to capture unit
  output logic univSerialDataIn_q, // Level to serial data in
  output logic univSerialClock_q, // Level to serial clock in
  output logic syncSerialExtClock_q, // Level to USART clock in
  output logic rxDataIn_q, // Level to USART receiver
  output logic [PINS-1:0] pinchangeLevelE_q, // Gated E levels
  output logic debugPullupEn_q, // Pull-ups on debug pins
  output logic toggleState_q // E4 toggle accumulated
);

  pdao_ovr_s ovrD [PINS];
  pdao_ovr_s ovrE [PINS];
  pdao_pad_s padD [PINS];
  pdao_pad_s padE [PINS];
  logic [PINS-1:0] pcE;
  logic [PINS-1:0] inD;
  logic [PINS-1:0] inE;
  logic portE4Eff;
  logic dieDef;
  logic xckOutEn;
  logic twoWire;
  logic outToggleOverrideEnable;

  function automatic pdao_pad_s pinEval(
    input pdao_ovr_s ov,
    input logic dir,
    input logic pv,
    input logic global_pullup_disable,
    input logic dieDefault
  );
    pdao_pad_s r;
    r.dirOut = ov.direction_override_enable ? ov.direction_override_value : dir;
    r.outVal = ov.outval_override_enable ? ov.outval_override_value : pv;
    r.pullEn = ov.pullup_override_enable ? ov.pullup_override_value : (~dir & pv & ~global_pullup_disable);
    r.inEn = ov.input_enable_override_enable ? ov.input_enable_override_value : dieDefault;
    return r;
  endfunction

  assign dieDef = ~sleepInputDisable;
  assign twoWire = univSerialTwowireMode;
  assign outToggleOverrideEnable = twoWire & clockToggleStrobe;
  assign pcE = pinchangeMaskE & {PINS{pinchangeGroup0Enable}};
  assign portE4Eff = portEOut[`PDAO_E_USICK] ^ toggleState_q;
  assign xckOutEn = usartSyncMode & portEDir[`PDAO_E_XCK];

  // Port D: only the irq pin has overrides; capture pin is a plain tap
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      ovrD[i] = '0;
    end
    ovrD[`PDAO_D_EXTIRQ0].input_enable_override_enable = extIrq0Enable;
    ovrD[`PDAO_D_EXTIRQ0].input_enable_override_value = extIrq0Enable;
  end

  // Port E override sources
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      ovrE[i] = '0;
      ovrE[i].input_enable_override_enable = pcE[i];
      ovrE[i].input_enable_override_value = 1'h1;
    end
    ovrE[`PDAO_E_CLKOUT].direction_override_enable = clockOutFuse;
    ovrE[`PDAO_E_CLKOUT].direction_override_value = 1'h1;
    ovrE[`PDAO_E_CLKOUT].outval_override_enable = clockOutFuse;
    ovrE[`PDAO_E_CLKOUT].outval_override_value = dividedClock;
    ovrE[`PDAO_E_USIDO].outval_override_enable = univSerialThreewireMode;
    ovrE[`PDAO_E_USIDO].outval_override_value = univSerialDataOut;
    ovrE[`PDAO_E_USIDI].pullup_override_enable = twoWire;
    ovrE[`PDAO_E_USIDI].pullup_override_value = 1'h0;
    ovrE[`PDAO_E_USIDI].direction_override_enable = twoWire;
    ovrE[`PDAO_E_USIDI].direction_override_value = (~univSerialSdaOut | portEOut[`PDAO_E_USIDI])
      & portEDir[`PDAO_E_USIDI];
    ovrE[`PDAO_E_USIDI].outval_override_enable = twoWire & portEDir[`PDAO_E_USIDI];
    ovrE[`PDAO_E_USIDI].outval_override_value = 1'h0;
    ovrE[`PDAO_E_USIDI].input_enable_override_enable = pcE[`PDAO_E_USIDI] | startDetectIrqEnable;
    ovrE[`PDAO_E_USICK].pullup_override_enable = twoWire;
    ovrE[`PDAO_E_USICK].pullup_override_value = 1'h0;
    ovrE[`PDAO_E_USICK].direction_override_enable = twoWire;
    ovrE[`PDAO_E_USICK].direction_override_value = (clockStretchHold | portE4Eff)
      & portEDir[`PDAO_E_USICK];
    ovrE[`PDAO_E_USICK].outval_override_enable = twoWire & portEDir[`PDAO_E_USICK];
    ovrE[`PDAO_E_USICK].outval_override_value = 1'h0;
    ovrE[`PDAO_E_USICK].input_enable_override_enable = pcE[`PDAO_E_USICK] | startDetectIrqEnable;
    ovrE[`PDAO_E_CMPNEG].input_enable_override_enable = pcE[`PDAO_E_CMPNEG] | cmpNegDinDisable;
    ovrE[`PDAO_E_CMPNEG].input_enable_override_value = pcE[`PDAO_E_CMPNEG];
    ovrE[`PDAO_E_XCK].input_enable_override_enable = pcE[`PDAO_E_XCK] | cmpPosDinDisable;
    ovrE[`PDAO_E_XCK].input_enable_override_value = pcE[`PDAO_E_XCK];
    ovrE[`PDAO_E_XCK].pullup_override_enable = xckOutEn;
    ovrE[`PDAO_E_XCK].pullup_override_value = 1'h0;
    ovrE[`PDAO_E_XCK].outval_override_enable = xckOutEn;
    ovrE[`PDAO_E_XCK].outval_override_value = syncSerialClockOut;
    ovrE[`PDAO_E_TXD].pullup_override_enable = transmitterEnableBit;
    ovrE[`PDAO_E_TXD].pullup_override_value = 1'h0;
    ovrE[`PDAO_E_TXD].direction_override_enable = transmitterEnableBit;
    ovrE[`PDAO_E_TXD].direction_override_value = 1'h1;
    ovrE[`PDAO_E_TXD].outval_override_enable = transmitterEnableBit;
    ovrE[`PDAO_E_TXD].outval_override_value = txData;
    ovrE[`PDAO_E_RXD].direction_override_enable = receiverEnableBit;
    ovrE[`PDAO_E_RXD].direction_override_value = 1'h0;
    ovrE[`PDAO_E_RXD].pullup_override_enable = receiverEnableBit;
    ovrE[`PDAO_E_RXD].pullup_override_value = portEOut[`PDAO_E_RXD]
      & ~globalPullupDisable;
  end

  // Per-pin resolution; E4 sees the toggled output bit
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      padD[i] = pinEval(ovrD[i], portDDir[i], portDOut[i], globalPullupDisable,
        dieDef);
      padE[i] = pinEval(ovrE[i], portEDir[i], (i == `PDAO_E_USICK) ? portE4Eff :
        portEOut[i], globalPullupDisable, dieDef);
      inD[i] = padD[i].inEn & portDPinIn[i];
      inE[i] = padE[i].inEn & portEPinIn[i];
    end
  end

  // Output toggle for the two-wire clock pin
  always_ff @(posedge clock) begin
    if (srst) begin
      toggleState_q <= `PDAO_RST_BIT;
    end else if (outToggleOverrideEnable) begin
      toggleState_q <= ~toggleState_q;
    end
  end

  // Port D pad drive values
  always_ff @(posedge clock) begin
    if (srst) begin
      portDOutVal_q <= `PDAO_RST_ZERO;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        portDOutVal_q[i] <= padD[i].outVal;
      end
    end
  end

  // Port D drive enables, low to drive
  always_ff @(posedge clock) begin
    if (srst) begin
      portDOeN_q <= `PDAO_RST_OEN;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        portDOeN_q[i] <= ~padD[i].dirOut;
      end
    end
  end

  // Port D pull-up enables
  always_ff @(posedge clock) begin
    if (srst) begin
      portDPullEn_q <= `PDAO_RST_ZERO;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        portDPullEn_q[i] <= padD[i].pullEn;
      end
    end
  end

  // Port D input buffer enables
  always_ff @(posedge clock) begin
    if (srst) begin
      portDInEn_q <= `PDAO_RST_ZERO;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        portDInEn_q[i] <= padD[i].inEn;
      end
    end
  end

  // Port E drive values; clock-out survives reset
  always_ff @(posedge clock) begin
    if (srst) begin
      portEOutVal_q <= `PDAO_RST_ZERO;
      if (clockOutFuse) begin
        portEOutVal_q[`PDAO_E_CLKOUT] <= dividedClock;
      end
    end else begin
      for (int i = 0; i < PINS; i++) begin
        portEOutVal_q[i] <= padE[i].outVal;
      end
    end
  end

  // Port E drive enables; clock-out pin stays driven in reset
  always_ff @(posedge clock) begin
    if (srst) begin
      portEOeN_q <= `PDAO_RST_OEN;
      if (clockOutFuse) begin
        portEOeN_q[`PDAO_E_CLKOUT] <= 1'h0;
      end
    end else begin
      for (int i = 0; i < PINS; i++) begin
        portEOeN_q[i] <= ~padE[i].dirOut;
      end
    end
  end

  // Port E pull-up enables
  always_ff @(posedge clock) begin
    if (srst) begin
      portEPullEn_q <= `PDAO_RST_ZERO;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        portEPullEn_q[i] <= padE[i].pullEn;
      end
    end
  end

  // Port E input buffer enables
  always_ff @(posedge clock) begin
    if (srst) begin
      portEInEn_q <= `PDAO_RST_ZERO;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        portEInEn_q[i] <= padE[i].inEn;
      end
    end
  end

  // Debug pin pull-ups follow the enable even in reset
  always_ff @(posedge clock) begin
    debugPullupEn_q <= jtagEnable;
  end

  // Levels handed to the peripherals
  always_ff @(posedge clock) begin
    if (srst) begin
      extIrq0Input_q <= `PDAO_RST_BIT;
      timer16CaptureInput_q <= `PDAO_RST_BIT;
      univSerialDataIn_q <= `PDAO_RST_BIT;
      univSerialClock_q <= `PDAO_RST_BIT;
      syncSerialExtClock_q <= `PDAO_RST_BIT;
      rxDataIn_q <= `PDAO_RST_BIT;
      pinchangeLevelE_q <= `PDAO_RST_ZERO;
    end else begin
      extIrq0Input_q <= inD[`PDAO_D_EXTIRQ0];
      timer16CaptureInput_q <= inD[`PDAO_D_CAPTURE];
      univSerialDataIn_q <= inE[`PDAO_E_USIDI];
      univSerialClock_q <= inE[`PDAO_E_USICK];
      syncSerialExtClock_q <= inE[`PDAO_E_XCK] & usartSyncMode;
      rxDataIn_q <= inE[`PDAO_E_RXD];
      pinchangeLevelE_q <= inE;
    end
  end

endmodule // pdao_port_mux

// *** sim/pdao_port_mux_asserts.sv ***
// Concurrent checks on the port D/E override block
module pdao_port_mux_asserts #(
  parameter int PINS = 8
) (
  input wire logic clock, // clock
  input wire logic srst, // reset
  input wire logic [PINS-1:0] portEOut, // E bits
  input wire logic globalPullupDisable, // no pulls
  input wire logic extIrq0Enable, // irq0 on
  input wire logic clockOutFuse, // fuse
  input wire logic dividedClock, // clk level
  input wire logic univSerialTwowireMode, // 2-wire
  input wire logic pinchangeGroup0Enable, // pc group
  input wire logic [PINS-1:0] pinchangeMaskE, // pc masks
  input wire logic cmpNegDinDisable, // E3 off
  input wire logic txData, // tx bit
  input wire logic transmitterEnableBit, // tx on
  input wire logic receiverEnableBit, // rx on
  input wire logic jtagEnable, // debug on
  input wire logic [PINS-1:0] portDInEn_q, // D in
  input wire logic [PINS-1:0] portEOutVal_q, // E val
  input wire logic [PINS-1:0] portEOeN_q, // E oe
  input wire logic [PINS-1:0] portEPullEn_q, // E pull
  input wire logic [PINS-1:0] portEInEn_q, // E in
  input wire logic debugPullupEn_q // debug pull
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  tx_pin_a: assert property (transmitterEnableBit |=> !portEOeN_q[1]
    && !portEPullEn_q[1] && portEOutVal_q[1] == $past(txData)) else $error("tx pin wrong");
  rx_pin_a: assert property (receiverEnableBit |=> portEOeN_q[0]
    && portEPullEn_q[0] == ($past(portEOut[0]) && !$past(globalPullupDisable)))
    else $error("rx pin wrong");
  clk_out_a: assert property (disable iff (1'b0) clockOutFuse |=> !portEOeN_q[7]
    && portEOutVal_q[7] == $past(dividedClock)) else $error("clock out wrong");
  debug_pull_a: assert property (disable iff (1'b0) jtagEnable |=> debugPullupEn_q)
    else $error("debug pull-up off");
  twowire_pull_a: assert property (univSerialTwowireMode |=> portEPullEn_q[5:4] == 2'h0)
    else $error("two-wire pull-up on");
  irq0_in_a: assert property (extIrq0Enable |=> portDInEn_q[1])
    else $error("irq0 input off");
  pc_input_a: assert property (pinchangeGroup0Enable && pinchangeMaskE[7]
    |=> portEInEn_q[7]) else $error("pin change input off");
  cmp_disable_a: assert property (cmpNegDinDisable && !(pinchangeGroup0Enable
    && pinchangeMaskE[3]) |=> !portEInEn_q[3]) else $error("E3 input on");
  cover property (transmitterEnableBit);
  cover property (disable iff (1'b0) srst && clockOutFuse);
  cover property (univSerialTwowireMode && portEOut[4]);
endmodule // pdao_port_mux_asserts
bind pdao_port_mux pdao_port_mux_asserts #(.PINS(PINS)) u_chk (.*);

// *** sim/pdao_pad_model.sv ***
// Pad and outside-world model for one 8-bit port
module pdao_pad_model (
  input wire logic clock, // clock
  input wire logic [7:0] oeN, // drive off
  input wire logic [7:0] outVal, // drive value
  input wire logic [7:0] pullEn, // pull-up
  input wire logic [7:0] ext, // outside level
  input wire logic [7:0] extEn, // outside drives
  output logic [7:0] pin // pad level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] flip_q = 8'h00;
  // Floating pad wanders each cycle
  always_ff @(posedge clock) flip_q <= ~flip_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = !oeN[i] ? outVal[i] : extEn[i] ? ext[i] : pullEn[i] ? 1'b1 : flip_q[i];
    end
  end
endmodule // pdao_pad_model

// *** sim/pdao_port_mux_tb.sv ***
// Self-checking bench for the port D/E override block
module pdao_port_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, srst = 1'b1, globalPullupDisable = 1'b0, sleepInputDisable = 1'b0;
  logic extIrq0Enable = 1'b0, clockOutFuse = 1'b0, dividedClock = 1'b1, usartSyncMode = 1'b0;
  logic univSerialTwowireMode = 1'b0, univSerialThreewireMode = 1'b0, univSerialSdaOut = 1'b1;
  logic univSerialDataOut = 1'b1, clockStretchHold = 1'b0, clockToggleStrobe = 1'b0;
  logic startDetectIrqEnable = 1'b0, pinchangeGroup0Enable = 1'b0, cmpPosDinDisable = 1'b0;
  logic cmpNegDinDisable = 1'b0, syncSerialClockOut = 1'b1, transmitterEnableBit = 1'b0;
  logic txData = 1'b1, receiverEnableBit = 1'b0, jtagEnable = 1'b0;
  logic [7:0] portDDir = 8'h00, portDOut = 8'h00, portEDir = 8'h00, portEOut = 8'h00;
  logic [7:0] pinchangeMaskE = 8'h00, extD = 8'h00, extE = 8'h00, extEnE = 8'h00;
  logic [7:0] portDPinIn, portEPinIn, portDOutVal_q, portDOeN_q, portDPullEn_q, portDInEn_q;
  logic [7:0] portEOutVal_q, portEOeN_q, portEPullEn_q, portEInEn_q, pinchangeLevelE_q;
  logic extIrq0Input_q, timer16CaptureInput_q, univSerialDataIn_q, univSerialClock_q;
  logic syncSerialExtClock_q, rxDataIn_q, debugPullupEn_q, toggleState_q;
  logic [47:0] r;
  int failCount = 0, checks = 0;
  // Control bits sdaLow,pud,sync,2w,3w,fuse,rx,tx; dir; out; oeN; val; pull
  localparam logic [47:0] ROWS [12] = '{48'h0000FFFFFFFF, 48'h010000FD0200,
    48'h02FF01010101, 48'h42FF01010100, 48'h0400007F8000, 48'h084000BF4000,
    48'h103030CF0000, 48'h902000DF0000, 48'h100030FF3000, 48'h200400FB0400,
    48'h000400FB0000, 48'h200004FF0404};
  pdao_port_mux u_dut (.*);
  pdao_pad_model u_padD (.clock(clock), .oeN(portDOeN_q), .outVal(portDOutVal_q),
    .pullEn(portDPullEn_q), .ext(extD), .extEn(8'hFF), .pin(portDPinIn));
  pdao_pad_model u_padE (.clock(clock), .oeN(portEOeN_q), .outVal(portEOutVal_q),
    .pullEn(portEPullEn_q), .ext(extE), .extEn(extEnE), .pin(portEPinIn));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic endOfTest;
    $display("checks=%0d failCount=%0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    failCount++;
    endOfTest();
  end
  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      r = ROWS[i];
      @(posedge clock);
      univSerialSdaOut <= !r[47];
      {globalPullupDisable, usartSyncMode, univSerialTwowireMode, univSerialThreewireMode,
        clockOutFuse, receiverEnableBit, transmitterEnableBit} <= r[46:40];
      portEDir <= r[39:32];
      portEOut <= r[31:24];
      tick();
      cmp8(portEOeN_q, r[23:16]);
      cmp8(portEOutVal_q, r[15:8]);
      cmp8(portEPullEn_q, r[7:0]);
      $display("row %0d done", i);
    end
    @(posedge clock);
    srst <= 1'b1;
    clockOutFuse <= 1'b1;
    jtagEnable <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      dividedClock <= k[0];
      tick();
      cmp8({7'h00, portEOutVal_q[7]}, {7'h00, k[0]});
      cmp8(portEOeN_q, 8'h7F);
      cmp8({7'h00, debugPullupEn_q}, 8'h01);
    end
    $display("reset test done");
    @(posedge clock);
    srst <= 1'b0;
    {clockOutFuse, jtagEnable, usartSyncMode} <= 3'h0;
    sleepInputDisable <= 1'b1;
    extIrq0Enable <= 1'b1;
    extD <= 8'h03;
    tick();
    cmp8(portDInEn_q, 8'h02);
    cmp8({7'h00, extIrq0Input_q}, 8'h01);
    @(posedge clock);
    sleepInputDisable <= 1'b0;
    tick();
    cmp8(portDOeN_q, 8'hFF);
    cmp8({7'h00, timer16CaptureInput_q}, 8'h01);
    $display("port D test done");
    @(posedge clock);
    {sleepInputDisable, pinchangeGroup0Enable} <= 2'h3;
    extIrq0Enable <= 1'b0;
    pinchangeMaskE <= 8'h81;
    {extE, extEnE} <= 16'hFFFF;
    tick();
    cmp8(portEInEn_q, 8'h81);
    cmp8(pinchangeLevelE_q, 8'h81);
    @(posedge clock);
    startDetectIrqEnable <= 1'b1;
    tick();
    cmp8(portEInEn_q, 8'hB1);
    @(posedge clock);
    {sleepInputDisable, startDetectIrqEnable} <= 2'h0;
    {cmpPosDinDisable, cmpNegDinDisable} <= 2'h3; // Port bits stay still
    pinchangeMaskE <= 8'h04;
    tick();
    cmp8(portEInEn_q, 8'hF7);
    $display("input enable test done");
    @(posedge clock);
    univSerialTwowireMode <= 1'b1;
    portEDir <= 8'h10;
    portEOut <= 8'h00;
    clockToggleStrobe <= 1'b1;
    @(posedge clock);
    clockToggleStrobe <= 1'b0;
    tick();
    cmp8(portEOeN_q, 8'hEF);
    @(posedge clock);
    univSerialTwowireMode <= 1'b0;
    clockToggleStrobe <= 1'b1;
    @(posedge clock);
    clockToggleStrobe <= 1'b0;
    tick();
    cmp8({7'h00, toggleState_q}, 8'h01);
    $display("toggle test done");
    @(posedge clock);
    {usartSyncMode, receiverEnableBit} <= 2'h3;
    portDDir <= 8'h01;
    portDOut <= 8'h03;
    portEDir <= 8'h00;
    extE <= 8'h24;
    tick();
    tick();
    cmp8(portDOeN_q, 8'hFE);
    cmp8(portDOutVal_q, 8'h03);
    cmp8(portDPullEn_q, 8'h02);
    cmp8({7'h00, univSerialDataIn_q}, 8'h01);
    cmp8({7'h00, univSerialClock_q}, 8'h00);
    cmp8({7'h00, syncSerialExtClock_q}, 8'h01);
    cmp8({7'h00, rxDataIn_q}, 8'h00);
    cmp8(pinchangeLevelE_q, 8'h24);
    $display("level test done");
    @(posedge clock);
    {usartSyncMode, receiverEnableBit} <= 2'h0;
    {univSerialTwowireMode, clockStretchHold} <= 2'h3;
    portEDir <= 8'h10;
    portEOut <= 8'h10;
    tick();
    cmp8(portEOeN_q, 8'hEF);
    @(posedge clock);
    clockStretchHold <= 1'b0;
    tick();
    cmp8(portEOeN_q, 8'hFF);
    $display("hold test done");
    endOfTest();
  end
endmodule // pdao_port_mux_tb
